//--- rtl/pmcm_map.vh
// constants for the power mode and clock manager
`ifndef PMCM_MAP_VH
`define PMCM_MAP_VH

// ===========================================
// power modes, one-hot
`define MODE_ACTIVE 4'h1
`define MODE_IDLE 4'h2
`define MODE_STANDBY 4'h4
`define MODE_SHUTDOWN 4'h8

// ===========================================
// mode request codes from software
`define REQ_IDLE 2'h1
`define REQ_STANDBY 2'h2
`define REQ_SHUTDOWN 2'h3

// ===========================================
// reset cause codes
`define CAUSE_POR 2'h0
`define CAUSE_RESET_PIN 2'h1
`define CAUSE_SHUTDOWN_PIN 2'h2

// ===========================================
// clock source selects
`define HS_SRC_RC 1'b0
`define HS_SRC_XTAL 1'b1
`define LS_SRC_RC 1'b0
`define LS_SRC_XTAL 1'b1

// ===========================================
// timing
`define HS_CLOCK_MHZ 48
`define MS_CLOCK_MHZ 2
`define LS_CLOCK_HZ 32768
`define LS_RC_HZ 32800
`define WAKE_SETTLE_NS 100
`define MCLK_PERIOD_NS 10

`endif

//--- rtl/pin_wake_detect.v
// per-pin latch and change detector for shutdown wake pins
`timescale 1ns/100ps
module pin_wake_detect (
  input wire mclk,
  input wire srst,
  input wire latchNow,
  input wire holdActive,
  input wire drive,
  input wire sense,
  input wire wakeEnable,
  output reg latched,
  output wire changed
);
  reg senseRef;

  // ===========================================
  // freeze the driven value, remember the sensed level
  always @(posedge mclk)
  begin
    if (srst)
    begin
      latched <= 1'b0;
      senseRef <= 1'b0;
    end
    else if (latchNow)
    begin
      latched <= drive;
      senseRef <= sense;
    end
  end

  assign changed = holdActive & wakeEnable & (sense != senseRef);
endmodule

//--- rtl/power_mode_clock_manager.v
// power mode sequencer, reset cause and system clock routing
// Behaviour
// - active mode runs cpu with flash and sram on; fast clock from crystal or rc
// - idle keeps enabled peripheral clocks; gates cpu core and memory clocks
// - any interrupt in idle returns to active
// - standby keeps always-on and sensor controller domains and sram powered; wakes on pin, rtc or sensor event once the entry settle time has run out
// - after standby the cpu resumes where it stopped, state retained
// - retained peripherals keep configuration through standby
// - all gpio held latched during the whole standby
// - shutdown powers off every domain including always-on and sensor controller
// - entering shutdown freezes each pin at its last driven value
// - change on a shutdown wake pin in shutdown starts a full reset
// - reset cause readable; shutdown-pin, reset-pin and power-on distinguished
// - across shutdown only latched io and flash survive
// - fast clock feeds cpu and peripherals from fast rc or crystal
// - radio always clocked from fast crystal oscillator
// - medium clock always from medium rc oscillator; feeds sensor and power
// - slow clock from slow rc or crystal; clocks rtc and radio timer resync
// - slow clock optionally routed to an output pin
// - sensor controller peripherals usable without waking cpu, and by cpu
`timescale 1ns/100ps
`include "pmcm_map.vh"
module power_mode_clock_manager #(
  parameter PIN_COUNT = 32,
  parameter SETTLE_NS = `WAKE_SETTLE_NS
) (
  input wire mclk,
  input wire srst,
  input wire powerOnReset,
  input wire resetPinAsserted,
  input wire modeRequestValid,
  input wire [1:0] modeRequest,
  input wire cpuHalted,
  input wire interruptPending,
  input wire externalWake,
  input wire rtcWake,
  input wire sensorWake,
  input wire highSpeedSourceSelect,
  input wire lowSpeedSourceSelect,
  input wire lowSpeedOutputEnable,
  input wire fastRcOscillator,
  input wire fastCrystalOscillator,
  input wire mediumRcOscillator,
  input wire slowRcOscillator,
  input wire slowCrystalOscillator,
  input wire [PIN_COUNT-1:0] pinDrive,
  input wire [PIN_COUNT-1:0] pinSense,
  input wire [PIN_COUNT-1:0] shutdownWakeEnable,
  input wire sensorOwnsPeripherals,
  output reg [3:0] powerMode,
  output wire modeRequestReady,
  output reg cpuClockEnable,
  output reg memoryClockEnable,
  output reg peripheralClockEnable,
  output reg flashPowered,
  output reg sramPowered,
  output reg sramRetain,
  output reg mainDomainPowered,
  output reg alwaysOnPowered,
  output reg sensorPowered,
  output reg registerRetain,
  output reg peripheralRetain,
  output reg resumeFromStandby,
  output reg ioHold,
  output reg [PIN_COUNT-1:0] pinOut,
  output reg fullResetRequest,
  output reg [1:0] resetCause,
  output wire highSpeedSystemClock,
  output wire radioClock,
  output wire mediumSpeedClock,
  output wire lowSpeedClock,
  output wire lowSpeedClockPin,
  output wire lowSpeedClockPinEnable,
  output wire sensorPeripheralGrant,
  output wire cpuPeripheralGrant
);
  // ===========================================
  // constants
  localparam integer SETTLE_TOTAL = (SETTLE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
  localparam [7:0] SETTLE_CYCLES = SETTLE_TOTAL[7:0];
  localparam [3:0] ST_ACTIVE = `MODE_ACTIVE;
  localparam [3:0] ST_IDLE = `MODE_IDLE;
  localparam [3:0] ST_STANDBY = `MODE_STANDBY;
  localparam [3:0] ST_SHUTDOWN = `MODE_SHUTDOWN;

  // ===========================================
  // state
  reg [3:0] next_powerMode;
  reg [1:0] pendingRequest;
  reg requestPending;
  reg [7:0] settleCount;
  reg shutdownArmed;
  wire [PIN_COUNT-1:0] latchedLevel;
  wire [PIN_COUNT-1:0] pinChanged;
  wire anyPinWake;
  wire standbyWake;
  wire latchNow;

  assign modeRequestReady = (powerMode == ST_ACTIVE) & ~requestPending;
  assign standbyWake = externalWake | rtcWake | sensorWake;
  assign latchNow = requestPending & cpuHalted & (powerMode == ST_ACTIVE);
  assign anyPinWake = |pinChanged;

  // ===========================================
  // per-pin latch and wake detect
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
    begin : pinSlice
      pin_wake_detect pinUnit (
        .mclk(mclk),
        .srst(srst),
        .latchNow(latchNow),
        .holdActive(shutdownArmed),
        .drive(pinDrive[gi]),
        .sense(pinSense[gi]),
        .wakeEnable(shutdownWakeEnable[gi]),
        .latched(latchedLevel[gi]),
        .changed(pinChanged[gi])
      );
    end
  endgenerate

  // ===========================================
  // mode transitions
  always @*
  begin
    next_powerMode = powerMode;
    case (powerMode)
      ST_ACTIVE:
      begin
        if (latchNow)
        begin
          if (pendingRequest == `REQ_IDLE)
            next_powerMode = ST_IDLE;
          else if (pendingRequest == `REQ_STANDBY)
            next_powerMode = ST_STANDBY;
          else if (pendingRequest == `REQ_SHUTDOWN)
            next_powerMode = ST_SHUTDOWN;
        end
      end
      ST_IDLE:
      begin
        if (interruptPending)
          next_powerMode = ST_ACTIVE;
      end
      ST_STANDBY:
      begin
        if (standbyWake && settleCount == 8'h00)
          next_powerMode = ST_ACTIVE;
      end
      ST_SHUTDOWN:
      begin
        next_powerMode = ST_SHUTDOWN;
      end
      default:
      begin
        next_powerMode = ST_ACTIVE;
      end
    endcase
    // a reset source forces active, so domain targets agree with the mode
    if (powerOnReset || resetPinAsserted)
      next_powerMode = ST_ACTIVE;
  end

  always @(posedge mclk)
  begin
    if (srst || powerOnReset || resetPinAsserted)
    begin
      powerMode <= ST_ACTIVE;
      requestPending <= 1'b0;
      pendingRequest <= 2'h0;
      settleCount <= 8'h00;
      shutdownArmed <= 1'b0;
      resumeFromStandby <= 1'b0;
    end
    else
    begin
      powerMode <= next_powerMode;
      if (modeRequestReady && modeRequestValid && modeRequest != 2'h0)
      begin
        requestPending <= 1'b1;
        pendingRequest <= modeRequest;
      end
      else if (latchNow)
        requestPending <= 1'b0;
      if (next_powerMode == ST_STANDBY && powerMode != ST_STANDBY)
        settleCount <= SETTLE_CYCLES;
      else if (settleCount != 8'h00)
        settleCount <= settleCount - 8'h01;
      shutdownArmed <= (next_powerMode == ST_SHUTDOWN);
      resumeFromStandby <= (powerMode == ST_STANDBY) && (next_powerMode == ST_ACTIVE);
    end
  end

  // ===========================================
  // reset cause and shutdown wake
  always @(posedge mclk)
  begin
    if (srst)
    begin
      resetCause <= `CAUSE_POR;
      fullResetRequest <= 1'b0;
    end
    else
    begin
      fullResetRequest <= shutdownArmed & anyPinWake & ~powerOnReset & ~resetPinAsserted;
      if (powerOnReset)
        resetCause <= `CAUSE_POR;
      else if (resetPinAsserted)
        resetCause <= `CAUSE_RESET_PIN;
      else if (shutdownArmed && anyPinWake)
        resetCause <= `CAUSE_SHUTDOWN_PIN;
    end
  end

  // ===========================================
  // domain targets for the mode being entered
  reg next_cpuClockEnable;
  reg next_memoryClockEnable;
  reg next_peripheralClockEnable;
  reg next_flashPowered;
  reg next_sramPowered;
  reg next_sramRetain;
  reg next_mainDomainPowered;
  reg next_alwaysOnPowered;
  reg next_sensorPowered;
  reg next_registerRetain;
  reg next_peripheralRetain;
  reg next_ioHold;

  always @*
  begin
    // everything off unless the target mode keeps it
    next_cpuClockEnable = 1'b0;
    next_memoryClockEnable = 1'b0;
    next_peripheralClockEnable = 1'b0;
    next_flashPowered = 1'b0;
    next_sramPowered = 1'b0;
    next_sramRetain = 1'b0;
    next_mainDomainPowered = 1'b0;
    next_alwaysOnPowered = 1'b0;
    next_sensorPowered = 1'b0;
    next_registerRetain = 1'b0;
    next_peripheralRetain = 1'b0;
    next_ioHold = 1'b0;
    case (next_powerMode)
      ST_ACTIVE:
      begin
        next_cpuClockEnable = 1'b1;
        next_memoryClockEnable = 1'b1;
        next_peripheralClockEnable = 1'b1;
        next_flashPowered = 1'b1;
        next_sramPowered = 1'b1;
        next_mainDomainPowered = 1'b1;
        next_alwaysOnPowered = 1'b1;
        next_sensorPowered = 1'b1;
      end
      ST_IDLE:
      begin
        next_peripheralClockEnable = 1'b1;
        next_flashPowered = 1'b1;
        next_sramPowered = 1'b1;
        next_mainDomainPowered = 1'b1;
        next_alwaysOnPowered = 1'b1;
        next_sensorPowered = 1'b1;
      end
      ST_STANDBY:
      begin
        next_sramPowered = 1'b1;
        next_sramRetain = 1'b1;
        next_alwaysOnPowered = 1'b1;
        next_sensorPowered = 1'b1;
        next_registerRetain = 1'b1;
        next_peripheralRetain = 1'b1;
        next_ioHold = 1'b1;
      end
      ST_SHUTDOWN:
      begin
        next_ioHold = 1'b1;
      end
      default:
      begin
        next_ioHold = 1'b0;
      end
    endcase
  end

  // ===========================================
  // domain power, clock gates and retention
  always @(posedge mclk)
  begin
    if (srst)
    begin
      cpuClockEnable <= 1'b1;
      memoryClockEnable <= 1'b1;
      peripheralClockEnable <= 1'b1;
      flashPowered <= 1'b1;
      sramPowered <= 1'b1;
      sramRetain <= 1'b0;
      mainDomainPowered <= 1'b1;
      alwaysOnPowered <= 1'b1;
      sensorPowered <= 1'b1;
      registerRetain <= 1'b0;
      peripheralRetain <= 1'b0;
      ioHold <= 1'b0;
    end
    else
    begin
      cpuClockEnable <= next_cpuClockEnable;
      memoryClockEnable <= next_memoryClockEnable;
      peripheralClockEnable <= next_peripheralClockEnable;
      flashPowered <= next_flashPowered;
      sramPowered <= next_sramPowered;
      sramRetain <= next_sramRetain;
      mainDomainPowered <= next_mainDomainPowered;
      alwaysOnPowered <= next_alwaysOnPowered;
      sensorPowered <= next_sensorPowered;
      registerRetain <= next_registerRetain;
      peripheralRetain <= next_peripheralRetain;
      ioHold <= next_ioHold;
    end
  end

  // ===========================================
  // pin drivers follow software until held
  always @(posedge mclk)
  begin
    if (srst)
      pinOut <= {PIN_COUNT{1'b0}};
    else if (powerMode == ST_STANDBY || powerMode == ST_SHUTDOWN)
      pinOut <= latchedLevel;
    else
      pinOut <= pinDrive;
  end

  // ===========================================
  // clock routing
  wire highSpeedRun;
  wire lowSpeedRun;
  assign highSpeedRun = (powerMode == ST_ACTIVE) | (powerMode == ST_IDLE);
  assign lowSpeedRun = (powerMode != ST_SHUTDOWN);
  assign highSpeedSystemClock = highSpeedRun &
    ((highSpeedSourceSelect == `HS_SRC_XTAL) ? fastCrystalOscillator : fastRcOscillator);
  assign radioClock = highSpeedRun & fastCrystalOscillator;
  assign mediumSpeedClock = lowSpeedRun & mediumRcOscillator;
  assign lowSpeedClock = lowSpeedRun &
    ((lowSpeedSourceSelect == `LS_SRC_XTAL) ? slowCrystalOscillator : slowRcOscillator);
  assign lowSpeedClockPinEnable = lowSpeedOutputEnable & lowSpeedRun;
  assign lowSpeedClockPin = lowSpeedClockPinEnable & lowSpeedClock;

  // ===========================================
  // sensor peripheral sharing
  assign sensorPeripheralGrant = sensorPowered & sensorOwnsPeripherals;
  assign cpuPeripheralGrant = cpuClockEnable & ~sensorOwnsPeripherals;
endmodule

//--- bench/pmcm_checker.sv
// port assertions for the power mode and clock manager
`timescale 1ns/100ps
`include "pmcm_map.vh"
module pmcm_checker #(
  parameter PIN_COUNT = 32
) (
  input wire mclk,
  input wire srst,
  input wire powerOnReset,
  input wire resetPinAsserted,
  input wire sensorOwnsPeripherals,
  input wire cpuHalted,
  input wire interruptPending,
  input wire highSpeedSourceSelect,
  input wire lowSpeedSourceSelect,
  input wire lowSpeedOutputEnable,
  input wire fastRcOscillator,
  input wire fastCrystalOscillator,
  input wire mediumRcOscillator,
  input wire slowRcOscillator,
  input wire slowCrystalOscillator,
  input wire [3:0] powerMode,
  input wire cpuClockEnable,
  input wire memoryClockEnable,
  input wire peripheralClockEnable,
  input wire flashPowered,
  input wire mainDomainPowered,
  input wire alwaysOnPowered,
  input wire sensorPowered,
  input wire resumeFromStandby,
  input wire ioHold,
  input wire [PIN_COUNT-1:0] pinOut,
  input wire fullResetRequest,
  input wire [1:0] resetCause,
  input wire highSpeedSystemClock,
  input wire radioClock,
  input wire mediumSpeedClock,
  input wire lowSpeedClock,
  input wire lowSpeedClockPinEnable,
  input wire sramPowered,
  input wire sramRetain,
  input wire registerRetain,
  input wire peripheralRetain,
  input wire lowSpeedClockPin,
  input wire sensorPeripheralGrant,
  input wire cpuPeripheralGrant
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_active_run: assert property (powerMode == `MODE_ACTIVE |-> cpuClockEnable && flashPowered
    && highSpeedSystemClock == (highSpeedSourceSelect ? fastCrystalOscillator : fastRcOscillator))
    else $error("active mode not running from the selected fast source");
  a_idle_gate: assert property (powerMode == `MODE_IDLE |-> !cpuClockEnable && !memoryClockEnable
    && peripheralClockEnable) else $error("idle clock gating wrong");
  a_idle_wake: assert property (powerMode == `MODE_IDLE && interruptPending |=> powerMode == `MODE_ACTIVE)
    else $error("interrupt did not end idle");
  a_standby_aon: assert property (powerMode == `MODE_STANDBY |-> alwaysOnPowered && !mainDomainPowered
    && ioHold) else $error("standby power or hold wrong");
  a_resume_pulse: assert property ($past(powerMode) == `MODE_STANDBY && powerMode == `MODE_ACTIVE
    && !$past(powerOnReset) && !$past(resetPinAsserted) |-> ##[0:1] resumeFromStandby)
    else $error("no resume pulse after standby");
  a_pin_freeze: assert property (ioHold && $past(ioHold) && $past(ioHold, 2) |-> $stable(pinOut))
    else $error("held pins moved");
  a_shutdown_off: assert property (powerMode == `MODE_SHUTDOWN |-> !alwaysOnPowered && !sensorPowered
    && ioHold) else $error("shutdown left a domain on");
  a_wake_cause: assert property ($rose(fullResetRequest) |-> powerMode == `MODE_SHUTDOWN
    && resetCause == `CAUSE_SHUTDOWN_PIN) else $error("pin wake without shutdown cause");
  a_entry_halt: assert property ($past(powerMode) == `MODE_ACTIVE && powerMode != `MODE_ACTIVE
    |-> $past(cpuHalted)) else $error("low power entered while cpu running");
  a_fixed_sources: assert property (powerMode == `MODE_ACTIVE |-> radioClock == fastCrystalOscillator
    && mediumSpeedClock == mediumRcOscillator) else $error("radio or medium clock source wrong");
  a_slow_route: assert property (powerMode == `MODE_ACTIVE |-> lowSpeedClockPinEnable == lowSpeedOutputEnable
    && lowSpeedClock == (lowSpeedSourceSelect ? slowCrystalOscillator : slowRcOscillator))
    else $error("slow clock routing wrong");
  a_standby_keep: assert property (powerMode == `MODE_STANDBY |-> sramPowered && sramRetain
    && registerRetain && peripheralRetain) else $error("standby retention wrong");
  a_shutdown_lose: assert property (powerMode == `MODE_SHUTDOWN |-> !sramPowered && !registerRetain
    && !peripheralRetain && !flashPowered) else $error("shutdown kept volatile state");
  a_slow_pin: assert property (lowSpeedClockPinEnable |-> lowSpeedClockPin == lowSpeedClock)
    else $error("slow clock pin does not follow slow clock");
  a_sensor_share: assert property (powerMode != `MODE_SHUTDOWN && sensorOwnsPeripherals
    |-> sensorPeripheralGrant) else $error("sensor lost its peripherals");
  a_cpu_share: assert property (powerMode == `MODE_ACTIVE && !sensorOwnsPeripherals
    |-> cpuPeripheralGrant) else $error("cpu denied sensor peripherals");
endmodule
bind power_mode_clock_manager pmcm_checker #(.PIN_COUNT(PIN_COUNT)) u_pmcm_checker (.mclk(mclk), .srst(srst),
  .cpuHalted(cpuHalted), .interruptPending(interruptPending), .highSpeedSourceSelect(highSpeedSourceSelect),
  .lowSpeedSourceSelect(lowSpeedSourceSelect), .lowSpeedOutputEnable(lowSpeedOutputEnable),
  .fastRcOscillator(fastRcOscillator), .fastCrystalOscillator(fastCrystalOscillator),
  .mediumRcOscillator(mediumRcOscillator), .slowRcOscillator(slowRcOscillator),
  .slowCrystalOscillator(slowCrystalOscillator), .powerMode(powerMode), .cpuClockEnable(cpuClockEnable),
  .memoryClockEnable(memoryClockEnable), .peripheralClockEnable(peripheralClockEnable),
  .flashPowered(flashPowered), .mainDomainPowered(mainDomainPowered), .alwaysOnPowered(alwaysOnPowered),
  .sensorPowered(sensorPowered), .resumeFromStandby(resumeFromStandby), .ioHold(ioHold), .pinOut(pinOut),
  .fullResetRequest(fullResetRequest), .resetCause(resetCause), .highSpeedSystemClock(highSpeedSystemClock),
  .radioClock(radioClock), .mediumSpeedClock(mediumSpeedClock), .lowSpeedClock(lowSpeedClock),
  .lowSpeedClockPinEnable(lowSpeedClockPinEnable), .powerOnReset(powerOnReset),
  .resetPinAsserted(resetPinAsserted), .sensorOwnsPeripherals(sensorOwnsPeripherals),
  .sramPowered(sramPowered), .sramRetain(sramRetain), .registerRetain(registerRetain),
  .peripheralRetain(peripheralRetain), .lowSpeedClockPin(lowSpeedClockPin),
  .sensorPeripheralGrant(sensorPeripheralGrant), .cpuPeripheralGrant(cpuPeripheralGrant));

//--- bench/cpu_partner.sv
// cpu model: stops executing a chosen number of cycles after a request is taken
`timescale 1ns/100ps
`include "pmcm_map.vh"
module cpu_partner (
  input wire mclk,
  input wire srst,
  input wire taken,
  input wire [3:0] powerMode,
  input wire [3:0] haltDelay,
  output reg cpuHalted
);
  reg pending;
  reg wasLow;
  reg [3:0] count;
  always @(posedge mclk)
  begin
    wasLow <= powerMode != `MODE_ACTIVE;
    if (srst)
    begin
      pending <= 1'b0;
      count <= 4'h0;
      cpuHalted <= 1'b0;
    end
    else if (taken)
    begin
      // a cpu that issues a request is running
      cpuHalted <= 1'b0;
      pending <= 1'b1;
      count <= haltDelay;
    end
    else if (pending && count != 4'h0)
      count <= count - 4'h1;
    else if (pending)
    begin
      cpuHalted <= 1'b1;
      pending <= 1'b0;
    end
    else if (powerMode == `MODE_ACTIVE && wasLow)
      cpuHalted <= 1'b0;
  end
endmodule

//--- bench/test_power_mode_clock_manager.sv
// self-checking bench for the power mode and clock manager
`timescale 1ns/100ps
`include "pmcm_map.vh"
module test_power_mode_clock_manager;
  localparam PINS = 8;
  reg mclk = 0, srst = 1, por = 0, rstPin = 0, reqValid = 0, irq = 0, hsSel = 0, lsSel = 0, lsOut = 0, scOwns = 0;
  reg fRc = 0, fXt = 0, mRc = 0, sRc = 0, sXt = 0;
  reg [2:0] wakes = 0;
  reg [1:0] reqCode = 0;
  reg [PINS-1:0] pinDrive = 0, pinSense = 0, wakeEn = 0, held;
  reg [3:0] haltDelay = 0;
  reg [3:0] lastMode = 4'h1;
  reg [3:0] expQ[$];
  wire cpuHalted, ready, fullReset, lsPinEn;
  wire [3:0] powerMode;
  wire [1:0] cause;
  wire [PINS-1:0] pinOut;
  integer seed = 32'h34c0, nMismatch = 0, numChecks = 0, i, w;
  always #5 mclk = ~mclk;
  always #1.1 fRc = ~fRc;
  always #1.3 fXt = ~fXt;
  always #2.7 mRc = ~mRc;
  always #6.1 sRc = ~sRc;
  always #7.3 sXt = ~sXt;
  power_mode_clock_manager #(.PIN_COUNT(PINS), .SETTLE_NS(50)) u_power_mode_clock_manager (.mclk(mclk),
    .srst(srst), .powerOnReset(por), .resetPinAsserted(rstPin), .modeRequestValid(reqValid),
    .modeRequest(reqCode), .cpuHalted(cpuHalted), .interruptPending(irq), .externalWake(wakes[0]),
    .rtcWake(wakes[1]), .sensorWake(wakes[2]), .highSpeedSourceSelect(hsSel), .lowSpeedSourceSelect(lsSel),
    .lowSpeedOutputEnable(lsOut), .fastRcOscillator(fRc), .fastCrystalOscillator(fXt), .mediumRcOscillator(mRc),
    .slowRcOscillator(sRc), .slowCrystalOscillator(sXt), .pinDrive(pinDrive), .pinSense(pinSense),
    .shutdownWakeEnable(wakeEn), .sensorOwnsPeripherals(scOwns), .powerMode(powerMode),
    .modeRequestReady(ready), .cpuClockEnable(), .memoryClockEnable(), .peripheralClockEnable(),
    .flashPowered(), .sramPowered(), .sramRetain(), .mainDomainPowered(), .alwaysOnPowered(), .sensorPowered(),
    .registerRetain(), .peripheralRetain(), .resumeFromStandby(), .ioHold(), .pinOut(pinOut),
    .fullResetRequest(fullReset), .resetCause(cause), .highSpeedSystemClock(), .radioClock(),
    .mediumSpeedClock(), .lowSpeedClock(), .lowSpeedClockPin(), .lowSpeedClockPinEnable(lsPinEn),
    .sensorPeripheralGrant(), .cpuPeripheralGrant());
  cpu_partner u_cpu_partner (.mclk(mclk), .srst(srst), .taken(reqValid && ready && reqCode != 2'h0),
    .powerMode(powerMode), .haltDelay(haltDelay), .cpuHalted(cpuHalted));
  // ===========================================
  // compare, wait and request helpers
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    numChecks = numChecks + 1;
    if (got !== exp)
    begin
      nMismatch = nMismatch + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task waitMode(input [3:0] m);
  begin
    for (i = 0; i < 40 && powerMode !== m; i = i + 1)
      @(negedge mclk);
    chk("mode reached", m, powerMode);
  end
  endtask
  task request(input [1:0] code, input [3:0] m);
  begin
    expQ.push_back(m);
    haltDelay = $random(seed);
    reqValid = 1;
    reqCode = code;
    @(negedge mclk);
    reqValid = 0;
    waitMode(m);
  end
  endtask
  task closeOut;
  begin
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // mode changes are matched against the oldest expected mode
  always @(posedge mclk)
  begin
    if (!srst && powerMode !== lastMode)
      chk("mode", expQ.size() ? expQ.pop_front() : lastMode, powerMode);
    lastMode <= powerMode;
  end
  initial
  begin
    #100000;
    nMismatch = nMismatch + 1;
    closeOut;
  end
  // ===========================================
  // scenarios
  initial
  begin
    repeat (12) @(negedge mclk);
    srst = 0;
    chk("reset mode", `MODE_ACTIVE, powerMode);
    chk("reset cause", `CAUSE_POR, cause);
    for (w = 0; w < 8; w = w + 1)
    begin
      {hsSel, lsSel, lsOut, scOwns} = $random(seed);
      @(negedge mclk);
      chk("slow pin enable", lsOut, lsPinEn);
    end
    $display("clock routing done");
    request(`REQ_IDLE, `MODE_IDLE);
    reqValid = 1;
    reqCode = `REQ_SHUTDOWN;
    repeat (3) @(negedge mclk);
    reqValid = 0;
    chk("refused request", `MODE_IDLE, powerMode);
    expQ.push_back(`MODE_ACTIVE);
    irq = 1;
    @(negedge mclk);
    irq = 0;
    $display("idle done");
    for (w = 0; w < 3; w = w + 1)
    begin
      pinDrive = $random(seed);
      held = pinDrive;
      request(`REQ_STANDBY, `MODE_STANDBY);
      pinDrive = ~held;
      wakes = 3'h1 << w;
      @(negedge mclk);
      wakes = 0;
      @(negedge mclk);
      chk("early wake", `MODE_STANDBY, powerMode);
      chk("held pins", held, pinOut);
      repeat (8) @(negedge mclk);
      expQ.push_back(`MODE_ACTIVE);
      wakes = 3'h1 << w;
      waitMode(`MODE_ACTIVE);
      wakes = 0;
    end
    $display("standby done");
    pinDrive = $random(seed);
    pinSense = pinDrive;
    held = pinDrive;
    wakeEn = 8'h10;
    request(`REQ_SHUTDOWN, `MODE_SHUTDOWN);
    pinDrive = 0;
    pinSense = pinSense ^ 8'h01;
    repeat (3) @(negedge mclk);
    chk("frozen pins", held, pinOut);
    chk("unenabled pin", 1'b0, fullReset);
    pinSense = pinSense ^ 8'h10;
    repeat (2) @(negedge mclk);
    chk("pin wake", 1'b1, fullReset);
    chk("pin wake cause", `CAUSE_SHUTDOWN_PIN, cause);
    expQ.push_back(`MODE_ACTIVE);
    rstPin = 1;
    @(negedge mclk);
    rstPin = 0;
    repeat (2) @(negedge mclk);
    chk("reset pin cause", `CAUSE_RESET_PIN, cause);
    por = 1;
    @(negedge mclk);
    por = 0;
    @(negedge mclk);
    chk("power-on cause", `CAUSE_POR, cause);
    chk("pending modes", 0, expQ.size());
    $display("shutdown done");
    closeOut;
  end
endmodule
